// ==== sim/spc_safety_pulse_counter_sva.sv ====
`timescale 1ns/1ps
module spc_chk(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic count_in,
  input wire logic clear_in,
  input wire logic clear_auto,
  input wire logic [15:0] count_target,
  input wire logic [15:0] count_value,
  input wire logic done,
  input wire logic target_invalid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_clr; !clear_auto && $past(clear_in, 3) |-> !done; endproperty
  a_clr: assert property (p_clr) else $error("done in clear");
  property p_ign; !clear_auto && $past(clear_in, 3) && $past(clear_in, 4)
    |-> $stable(count_value); endproperty
  a_ign: assert property (p_ign) else $error("count in clear");
  property p_sat; !clear_auto && done && !$past(clear_in, 2)
    |=> done && $stable(count_value); endproperty
  a_sat: assert property (p_sat) else $error("done lost");
  property p_auto; clear_auto && done && $past(count_in, 2) |=> done;
  endproperty
  a_auto: assert property (p_auto) else $error("auto drop");
  property p_edge; $changed(count_value) && $past(reset_n) |->
    $past(count_in, 3) != $past(count_in, 4) || $past(clear_in, 3);
  endproperty
  a_edge: assert property (p_edge) else $error("stray count");
  property p_tgt; target_invalid == ($past(count_target) == 16'h0000);
  endproperty
  a_tgt: assert property (p_tgt) else $error("target flag");
endmodule : spc_chk
bind spc_safety_pulse_counter spc_chk u_spc_chk(.core_clk(core_clk),
  .reset_n(reset_n), .count_in(count_in), .clear_in(clear_in),
  .clear_auto(clear_auto), .count_target(count_target),
  .count_value(count_value), .done(done),
  .target_invalid(target_invalid));

// ==== sim/spc_safety_pulse_counter_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("[ERR] %0t %h %h", $time, a, e); end end
module spc_safety_pulse_counter_tb;
  import spc_pkg::*;
  logic core_clk = 0, reset_n = 0, clear_in = 0, count_up = 0;
  logic clear_auto = 0, count_in, done, target_invalid;
  logic [15:0] count_target = 16'h0003, count_value;
  int miscompares = 0, total_checks = 0;
  spc_safety_pulse_counter u_spc_safety_pulse_counter(.core_clk(core_clk),
    .reset_n(reset_n), .count_in(count_in), .clear_in(clear_in),
    .count_up(count_up), .clear_auto(clear_auto),
    .count_target(count_target), .count_value(count_value), .done(done),
    .target_invalid(target_invalid));
  spc_src u_spc_src(.core_clk(core_clk), .count_in(count_in));
  initial forever #2 core_clk = ~core_clk;
  task end_sim;
    $display("miscompares %0d checks %0d", miscompares, total_checks);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task clr;
    @(negedge core_clk) clear_in = 1;
    repeat (5) @(negedge core_clk);
    clear_in = 0;
    repeat (4) @(negedge core_clk);
  endtask : clr
  task pls;
    u_spc_src.lvl(1);
    u_spc_src.lvl(0);
  endtask : pls
  initial begin #4000 miscompares++; end_sim; end
  initial begin
    repeat (8) @(negedge core_clk);
    reset_n = 1;
    `CHK({target_invalid, count_value}, 17'h0_0001)
    clr;
    `CHK(count_value, 16'h0003)
    u_spc_src.lvl(1);
    `CHK(count_value, 16'h0002)
    u_spc_src.lvl(0);
    `CHK(count_value, 16'h0002)
    repeat (2) pls;
    `CHK({done, count_value}, 17'h1_0000)
    pls;
    `CHK(count_value, 16'h0000)
    clr;
    `CHK({done, count_value}, 17'h0_0003)
    clear_in = 1;
    pls;
    `CHK({done, count_value}, 17'h0_0003)
    clear_in = 0;
    repeat (4) @(negedge core_clk);
    pls;
    `CHK({done, count_value}, 17'h0_0002)
    count_up = 1;
    count_target = 16'h0002;
    clr;
    `CHK(count_value, 16'h0000)
    clear_auto = 1;
    pls;
    u_spc_src.lvl(1);
    `CHK({done, count_value}, 17'h1_0002)
    u_spc_src.lvl(0);
    `CHK({done, count_value}, 17'h0_0000)
    clear_auto = 0;
    count_up = 0;
    count_target = 16'h0000;
    clr;
    `CHK({target_invalid, count_value}, 17'h1_0001)
    pls;
    `CHK({done, count_value}, 17'h1_0000)
    end_sim;
  end
endmodule : spc_safety_pulse_counter_tb

// ==== sim/spc_src.sv ====
`timescale 1ns/1ps
module spc_src(
  input wire logic core_clk,
  output logic count_in = 1'b0
);
  // Each level held five scans so every edge is seen
  task lvl(input logic v);
    @(negedge core_clk) count_in = v;
    repeat (5) @(negedge core_clk);
  endtask : lvl
endmodule : spc_src

// ==== verilog/spc_pkg.sv ====
package spc_pkg;
  localparam int SPC_CNT_W = 16;
  localparam logic [15:0] SPC_TARGET_MIN = 16'h0001;
  localparam logic [15:0] SPC_TARGET_DEF = 16'h0001;
  localparam logic [15:0] SPC_COUNT_ZERO = 16'h0000;
  localparam logic [15:0] SPC_COUNT_STEP = 16'h0001;
  localparam logic [15:0] SPC_COUNT_RST = 16'h0001;
  localparam logic SPC_DIR_DOWN = 1'b0;
  localparam logic SPC_DIR_UP = 1'b1;
  localparam logic SPC_CLR_MANUAL = 1'b0;
  localparam logic SPC_CLR_AUTO = 1'b1;

  typedef enum logic {SPC_COUNTING, SPC_DONE} spc_state_t;

  typedef struct packed {
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_prev;
    logic clr_s1;
    logic clr_s2;
    logic [15:0] count_value;
    logic done;
    logic tgt_bad;
    spc_state_t state;
  } spc_regs_t;
endpackage : spc_pkg

// ==== verilog/spc_safety_pulse_counter.sv ====
`timescale 1ns/1ps
module spc_safety_pulse_counter
  import spc_pkg::*;
#(
  parameter int CNT_W = SPC_CNT_W
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic count_in,
  input wire logic clear_in,
  input wire logic count_up,
  input wire logic clear_auto,
  input wire logic [15:0] count_target,
  output logic [15:0] count_value,
  output logic done,
  output logic target_invalid
);

  // Ports and state are sixteen bits wide; other widths are refused
  if (CNT_W != SPC_CNT_W) begin : g_bad_width
    $error("spc_safety_pulse_counter: CNT_W must be 16");
  end

  spc_regs_t r_ff;
  spc_regs_t nxt_r;
  logic tgt_zero;
  logic [15:0] tgt;
  logic [15:0] start_val;
  logic [15:0] term_val;
  logic [15:0] stepped;
  logic rise;
  logic manual_clr;
  logic auto_release;

  // Direction decode, shared by start, terminal and step
  function automatic logic dir_is_up(
    input logic dir
  );
    dir_is_up = (dir == SPC_DIR_UP);
  endfunction : dir_is_up

  // Zero is outside the target range
  function automatic logic target_bad(
    input logic [15:0] target
  );
    target_bad = (target < SPC_TARGET_MIN);
  endfunction : target_bad

  function automatic logic [15:0] start_of(
    input logic dir,
    input logic [15:0] target
  );
    if (dir_is_up(dir)) begin
      start_of = SPC_COUNT_ZERO;
    end else begin
      start_of = target;
    end
  endfunction : start_of

  function automatic logic [15:0] term_of(
    input logic dir,
    input logic [15:0] target
  );
    if (dir_is_up(dir)) begin
      term_of = target;
    end else begin
      term_of = SPC_COUNT_ZERO;
    end
  endfunction : term_of

  // Wraps only if the target moves to or below the count while counting up, count_up changes in mid-count, or an up count to target 1 starts from reset
  function automatic logic [15:0] step_of(
    input logic dir,
    input logic [15:0] value
  );
    if (dir_is_up(dir)) begin
      step_of = value + SPC_COUNT_STEP;
    end else begin
      step_of = value - SPC_COUNT_STEP;
    end
  endfunction : step_of

  function automatic logic edge_up(
    input logic cur,
    input logic prev
  );
    edge_up = cur && !prev;
  endfunction : edge_up

  // Target of zero is out of range; fall back to default
  always_comb begin
    tgt_zero = target_bad(count_target);
    if (tgt_zero) begin
      tgt = SPC_TARGET_DEF;
    end else begin
      tgt = count_target;
    end
    start_val = start_of(count_up, tgt);
    term_val = term_of(count_up, tgt);
    stepped = step_of(count_up, r_ff.count_value);
  end

  always_comb begin
    nxt_r = r_ff;
    // Two stages since both inputs may be asynchronous to this clock
    nxt_r.cnt_s1 = count_in;
    nxt_r.cnt_s2 = r_ff.cnt_s1;
    nxt_r.clr_s1 = clear_in;
    nxt_r.clr_s2 = r_ff.clr_s1;
    nxt_r.cnt_prev = r_ff.cnt_s2;
    nxt_r.tgt_bad = tgt_zero;
    rise = edge_up(r_ff.cnt_s2, r_ff.cnt_prev);
    manual_clr = (clear_auto == SPC_CLR_MANUAL) && r_ff.clr_s2;
    auto_release = (clear_auto == SPC_CLR_AUTO) && !r_ff.cnt_s2;
    // Clear wins over a count edge in the same scan
    if (manual_clr) begin
      nxt_r.count_value = start_val;
      nxt_r.done = 1'b0;
      nxt_r.state = SPC_COUNTING;
    end else begin
      unique case (r_ff.state)
        SPC_COUNTING: begin
          if (rise) begin
            nxt_r.count_value = stepped;
            if (stepped == term_val) begin
              nxt_r.done = 1'b1;
              nxt_r.state = SPC_DONE;
            end
          end
        end
        SPC_DONE: begin
          // Count held at terminal value until auto release reloads the start value
          if (auto_release) begin
            nxt_r.count_value = start_val;
            nxt_r.done = 1'b0;
            nxt_r.state = SPC_COUNTING;
          end
        end
      endcase
    end
  end

  // Reset loads the default down start; other setups need one clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_ff <= '{cnt_s1: 1'b0,
                cnt_s2: 1'b0,
                cnt_prev: 1'b0,
                clr_s1: 1'b0,
                clr_s2: 1'b0,
                count_value: SPC_COUNT_RST,
                done: 1'b0,
                tgt_bad: 1'b0,
                state: SPC_COUNTING};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign count_value = r_ff.count_value;
  assign done = r_ff.done;
  assign target_invalid = r_ff.tgt_bad;

endmodule : spc_safety_pulse_counter
